// File: rtl/ipf_bank.sv
// Purpose: apb bank of interrupt priority fields
// Assumes: single clock, zero-wait apb slave
// Notes: source request lines and levels exposed for the arbiter
`timescale 1ns/1ps
`default_nettype none
`include "ipf_regs.svh"
module ipf_bank
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic [3:0]  srcReq,
	output logic [3:0]       gatedReq,
	output logic [11:0]      levels
);
	logic        wrAcc;
	logic        hitExt;
	logic        hitTmr;
	logic [3:0]  wrEn;
	logic [11:0] wrVal;
	logic [3:0]  lowLane;
	logic [3:0]  highLane;
	logic [2:0]  lv [4];
	logic [15:0] rdExt;
	logic [15:0] rdTmr;
	logic [15:0] rdSel;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic        setupPh;
	logic [31:0] prdata_next;
	logic        pslverr_next;

	function automatic logic [2:0] fieldOf(input logic [31:0] w, input int lsb);
		fieldOf = w[lsb +: 3];
	endfunction

	assign hitExt = (paddr == `IPF_EXT1_OFS);
	assign hitTmr = (paddr == `IPF_TMR_OFS);
	assign wrAcc = psel & penable & pwrite;
	assign lowLane = {4{pstrb[0]}};
	assign highLane = {4{pstrb[1]}};
	// byte lane 0 carries ext1 and oc3, lane 1 carries t4 and oc4
	assign wrEn[ipf_pkg::IPF_EXT1] = wrAcc & hitExt & lowLane[0];
	assign wrEn[ipf_pkg::IPF_T4] = wrAcc & hitTmr & highLane[0];
	assign wrEn[ipf_pkg::IPF_OC4] = wrAcc & hitTmr & highLane[1];
	assign wrEn[ipf_pkg::IPF_OC3] = wrAcc & hitTmr & lowLane[1];
	assign wrVal = {fieldOf(pwdata, `IPF_EXT1_LSB), fieldOf(pwdata, `IPF_T4_LSB),
		fieldOf(pwdata, `IPF_OC4_LSB), fieldOf(pwdata, `IPF_OC3_LSB)};

	genvar g;
	generate
		for (g = 0; g < `IPF_NSRC; g++)
		begin : gFld
			ipf_field uFld
			(
				.mclk         (mclk),
				.rst_b        (rst_b),
				.wrEn         (wrEn[g]),
				.wrData       (wrVal[11 - 3*g -: 3]),
				.srcReq       (srcReq[g]),
				.fieldEnabled (),
				.level        (lv[g]),
				.gatedReq     (gatedReq[g])
			);
		end
	endgenerate

	assign levels = {lv[3], lv[2], lv[1], lv[0]};
	// unimplemented bits are hard zero, no storage behind them
	assign rdExt = {13'h0000, lv[ipf_pkg::IPF_EXT1]};
	assign rdTmr = {1'h0, lv[ipf_pkg::IPF_T4], 1'h0, lv[ipf_pkg::IPF_OC4],
		1'h0, lv[ipf_pkg::IPF_OC3], 4'h0};
	assign rdSel = hitExt ? rdExt : (hitTmr ? rdTmr : 16'h0000);
	assign setupPh = psel & !penable;
	// data registered in setup so access phase has zero wait
	assign prdata_next = setupPh ? {16'h0000, rdSel} : prdata_reg;
	// unmapped offsets answer with an error, never a hang
	assign pslverr_next = setupPh ? !(hitExt | hitTmr) : pslverr_reg;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			prdata_reg <= 32'h0000_0000;
		else
			prdata_reg <= prdata_next;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			pslverr_reg <= 1'h0;
		else
			pslverr_reg <= pslverr_next;
	end

	assign pready = 1'h1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;

	property p_reset_level;
		@(posedge mclk) $rose(rst_b) |-> (lv[0] == `IPF_FLD_RST);
	endproperty
	a_reset_level: assert property (p_reset_level) else $error("field not at reset value");

	property p_ext_write;
		@(posedge mclk) disable iff (!rst_b)
		(wrAcc & hitExt & pstrb[0]) |=> (lv[0] == $past(pwdata[2:0]));
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("ext1 field write lost");

	property p_ext_upper_zero;
		@(posedge mclk) disable iff (!rst_b)
		(psel & !penable & hitExt) |=> (prdata[31:3] == 29'h0);
	endproperty
	a_ext_upper_zero: assert property (p_ext_upper_zero) else $error("ext1 upper bits nonzero");

	property p_tmr_zero;
		@(posedge mclk) disable iff (!rst_b)
		(psel & !penable & hitTmr) |=>
		(prdata[15] == 1'h0 && prdata[11] == 1'h0 && prdata[7] == 1'h0 && prdata[3:0] == 4'h0);
	endproperty
	a_tmr_zero: assert property (p_tmr_zero) else $error("reserved bits nonzero");

	property p_t4_place;
		@(posedge mclk) disable iff (!rst_b)
		(psel & !penable & hitTmr) |=> (prdata[14:12] == $past(lv[1]));
	endproperty
	a_t4_place: assert property (p_t4_place) else $error("timer4 field misplaced");

	property p_disabled;
		@(posedge mclk) disable iff (!rst_b)
		(lv[0] == 3'h0) |-> !gatedReq[0];
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled source requested");

	property p_enabled;
		@(posedge mclk) disable iff (!rst_b)
		(lv[1] != 3'h0 && srcReq[1]) |-> gatedReq[1];
	endproperty
	a_enabled: assert property (p_enabled) else $error("enabled source blocked");

	property p_level_pass;
		@(posedge mclk) disable iff (!rst_b)
		(wrAcc & hitTmr & pstrb[1] & (pwdata[14:12] == 3'h7)) |=> (levels[5:3] == 3'h7);
	endproperty
	a_level_pass: assert property (p_level_pass) else $error("level 7 not passed");

	sequence s_ext_setup;
		psel & !penable & hitExt;
	endsequence

	sequence s_tmr_setup;
		psel & !penable & hitTmr;
	endsequence

	sequence s_ext_write;
		wrAcc & hitExt;
	endsequence

	sequence s_tmr_write;
		wrAcc & hitTmr;
	endsequence

	property p_ext_read;
		@(posedge mclk) disable iff (!rst_b)
		s_ext_setup |=> (prdata[2:0] == $past(lv[0]));
	endproperty
	a_ext_read: assert property (p_ext_read) else $error("ext1 field not read back");

	property p_ext_lane;
		@(posedge mclk) disable iff (!rst_b)
		(s_ext_write ##0 !pstrb[0]) |=> $stable(lv[0]);
	endproperty
	a_ext_lane: assert property (p_ext_lane) else $error("ext1 written without lane");

	property p_tmr_write;
		@(posedge mclk) disable iff (!rst_b)
		(s_tmr_write ##0 pstrb[1]) |=> (lv[1] == $past(pwdata[14:12]));
	endproperty
	a_tmr_write: assert property (p_tmr_write) else $error("timer4 field write lost");

	property p_oc_write;
		@(posedge mclk) disable iff (!rst_b)
		(s_tmr_write ##0 (pstrb[1] & pstrb[0])) |=>
		(lv[2] == $past(pwdata[10:8]) && lv[3] == $past(pwdata[6:4]));
	endproperty
	a_oc_write: assert property (p_oc_write) else $error("compare field write lost");

	property p_oc_place;
		@(posedge mclk) disable iff (!rst_b)
		s_tmr_setup |=> (prdata[10:8] == $past(lv[2]) && prdata[6:4] == $past(lv[3]));
	endproperty
	a_oc_place: assert property (p_oc_place) else $error("compare field misplaced");

	property p_reset_all;
		@(posedge mclk) $rose(rst_b) |-> (levels == {4{`IPF_FLD_RST}});
	endproperty
	a_reset_all: assert property (p_reset_all) else $error("fields not at reset value");

	property p_gate_all;
		@(posedge mclk) disable iff (!rst_b)
		((lv[1] == 3'h0) -> !gatedReq[1]) && ((lv[2] == 3'h0) -> !gatedReq[2]) &&
		((lv[3] == 3'h0) -> !gatedReq[3]);
	endproperty
	a_gate_all: assert property (p_gate_all) else $error("disabled source requested");

	property p_ext_top;
		@(posedge mclk) disable iff (!rst_b)
		(s_ext_write ##0 (pstrb[0] & (pwdata[2:0] == 3'h7))) |=> (levels[2:0] == 3'h7);
	endproperty
	a_ext_top: assert property (p_ext_top) else $error("ext1 level 7 not passed");
endmodule
`default_nettype wire

// File: rtl/ipf_regs.svh
// Purpose: offsets, field positions and reset values of the priority registers
// Assumes: apb byte addresses, one aligned word per register
// Notes: none
`ifndef IPF_REGS_SVH
`define IPF_REGS_SVH
`define IPF_EXT1_OFS     12'h000
`define IPF_TMR_OFS      12'h004
`define IPF_ADDR_W       12
`define IPF_FLD_RST      3'h4
`define IPF_EXT1_LSB     0
`define IPF_T4_LSB       12
`define IPF_OC4_LSB      8
`define IPF_OC3_LSB      4
`define IPF_NSRC         4
`endif

// File: rtl/ipf_pkg.sv
// Purpose: types of the priority field bank
// Assumes: none
// Notes: none
package ipf_pkg;
	typedef logic [2:0] ipf_level_t;
	typedef enum logic [1:0]
	{
		IPF_EXT1 = 2'h0,
		IPF_T4   = 2'h1,
		IPF_OC4  = 2'h2,
		IPF_OC3  = 2'h3
	} ipf_src_e;
endpackage

// File: rtl/ipf_field.sv
// Purpose: one 3-bit priority field with its decoded request gate
// Assumes: write strobe is a one-cycle pulse
// Notes: reset loads priority 4
`timescale 1ns/1ps
`default_nettype none
`include "ipf_regs.svh"
module ipf_field
(
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                wrEn,
	input  wire ipf_pkg::ipf_level_t wrData,
	input  wire logic                srcReq,
	output logic                     fieldEnabled,
	output ipf_pkg::ipf_level_t      level,
	output logic                     gatedReq
);
	ipf_pkg::ipf_level_t level_reg;
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			level_reg <= `IPF_FLD_RST;
		else if (wrEn)
			level_reg <= wrData;
	end
	assign level = level_reg;
	// code zero keeps the source from ever requesting
	assign fieldEnabled = (level_reg != 3'h0);
	assign gatedReq = srcReq & fieldEnabled;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench of the priority field bank
// Assumes: apb slave raising pready within 19 access-phase cycles, rows applied in order
// Notes: state carries from row to row
`timescale 1ns/1ps
`default_nettype none
`include "ipf_regs.svh"
module testbench;
	logic        mclk = 1'h0;
	logic        rst_b = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [3:0]  srcReq = 4'hF;
	logic        pready;
	logic        pslverr;
	logic        e;
	logic [31:0] prdata;
	logic [31:0] q;
	logic [3:0]  gatedReq;
	logic [11:0] levels;
	int          err_total = 0;
	int          checks = 0;
	// addr, wdata, strb, readback, levels, gated with all sources requesting
	logic [79:0] rows [8] = '{
		80'h000_FFFFFFFF_F_0007_927_F, 80'h004_FFFFFFFF_F_7770_FFF_F,
		80'h000_00000000_F_0000_FF8_E, 80'h004_00005321_F_5320_4E8_E,
		80'h000_00000001_F_0001_4E9_F, 80'h004_00000000_F_0000_001_1,
		80'h004_00006000_2_6000_031_3, 80'h004_00006070_2_6000_031_3};
	always #4 mclk = ~mclk;
	ipf_bank dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .srcReq(srcReq),
		.gatedReq(gatedReq), .levels(levels));
	task automatic results;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpLvl(input logic [11:0] got, input logic [11:0] exp);
		cmp({20'h0, got}, {20'h0, exp});
	endtask
	task automatic cmpReq(input logic [3:0] got, input logic [3:0] exp);
		cmp({28'h0, got}, {28'h0, exp});
	endtask
	task automatic cmpErr(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic er);
		int n;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'h1;
		n = 0;
		// no wait count assumed, only a bound against a hang
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (n >= 20)
		begin
			err_total++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chkRst;
		apb(1'h0, `IPF_EXT1_OFS, 32'h0, 4'h0, q, e);
		cmp(q, 32'h4);
		apb(1'h0, `IPF_TMR_OFS, 32'h0, 4'h0, q, e);
		cmp(q, 32'h4440);
		cmpLvl(levels, 12'h924);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'h1;
		chkRst();
		foreach (rows[i])
		begin
			apb(1'h1, rows[i][79:68], rows[i][67:36], rows[i][35:32], q, e);
			apb(1'h0, rows[i][79:68], 32'h0, 4'h0, q, e);
			cmp(q, {16'h0, rows[i][31:16]});
			cmpLvl(levels, rows[i][15:4]);
			cmpReq(gatedReq, rows[i][3:0]);
		end
		srcReq <= 4'h0;
		apb(1'h1, 12'h008, 32'hFFFF, 4'hF, q, e);
		cmpErr(e, 1'h1);
		cmpReq(gatedReq, 4'h0);
		apb(1'h0, 12'h008, 32'h0, 4'h0, q, e);
		cmpErr(e, 1'h1);
		cmp(q, 32'h0);
		// ext1 lives in lane 0, so a write without that lane must not land
		apb(1'h1, `IPF_EXT1_OFS, 32'h7, 4'hE, q, e);
		apb(1'h0, `IPF_EXT1_OFS, 32'h0, 4'h0, q, e);
		cmp(q, 32'h1);
		srcReq <= 4'hF;
		rst_b <= 1'h0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'h1;
		chkRst();
		results();
	end
endmodule
`default_nettype wire
